//--- drb_reset_bus_release.sv
// Reset sequencing of the external memory and I/O bus
`timescale 1ns/1ns
module drb_reset_bus_release
  import drb_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          SRST_I,
  input  wire logic          CE_I,
  input  wire logic          RESET_IN_N_I,
  input  wire logic          MEMORY_MODE_SELECT_I,
  input  wire logic          RD_REQ_I,
  input  wire logic          WR_REQ_I,
  input  wire logic [DW-1:0] WR_DATA_I,
  output logic               CLOCK_OUT_O,
  output logic               RD_N_O,
  output logic               WR_N_O,
  output logic               STROBE_OE_O,
  output logic [AW-1:0]      ADDRESS_BUS_O,
  output logic               ADDRESS_BUS_OE_O,
  output logic [DW-1:0]      DATA_BUS_O,
  output logic               DATA_BUS_OE_O,
  output logic               MODE_LATCHED_O,
  output logic               RUN_O
);
  // ************************************
  // Reset input synchroniser
  // ************************************
  logic rst_n_sync;

  drb_sync u_sync (
    .clk_i   (REF_CLK_I),
    .ce_i    (CE_I),
    .srst_i  (SRST_I),
    .async_i (RESET_IN_N_I),
    .sync_o  (rst_n_sync)
  );

  // ************************************
  // Sequencer
  // ************************************
  drb_state_t    state_q, state_d;
  drb_bus_t      bus_q, bus_d;
  logic [AW-1:0] pc_q, pc_d;
  logic          clk_out_q, clk_out_d;
  logic          mode_q, mode_d;
  logic          run_q, run_d;

  function automatic logic [AW-1:0] pc_next(input logic [AW-1:0] pc);
    return pc + AW'(1);
  endfunction

  always_comb begin
    state_d   = state_q;
    bus_d     = bus_q;
    pc_d      = pc_q;
    clk_out_d = ~clk_out_q;
    mode_d    = mode_q;
    run_d     = run_q;
    unique case (state_q)
      ST_RUN: begin
        if (!rst_n_sync) begin
          // Strobes high while still driven, floating comes a cycle later
          bus_d.rd_n = 1'b1;
          bus_d.wr_n = 1'b1;
          bus_d.data_oe = 1'b0;
          run_d = 1'b0;
          state_d = ST_STROBE;
        end else begin
          // Read wins over write so strobes never overlap
          bus_d.rd_n    = ~RD_REQ_I;
          bus_d.wr_n    = ~(WR_REQ_I & ~RD_REQ_I);
          bus_d.data    = WR_DATA_I;
          bus_d.data_oe = WR_REQ_I & ~RD_REQ_I;
          bus_d.addr    = pc_q;
          pc_d          = pc_next(pc_q);
        end
      end
      ST_STROBE: begin
        bus_d.strobe_oe = 1'b0;
        bus_d.addr_oe   = 1'b0;
        bus_d.data_oe   = 1'b0;
        state_d = ST_FLOAT;
      end
      ST_FLOAT: begin
        // One full clock after the edge, address and counter clear
        pc_d       = PC_RESET;
        bus_d.addr = PC_RESET;
        bus_d.data = DATA_RESET;
        state_d    = ST_HOLD;
      end
      ST_HOLD: begin
        // Short pulses are tolerated, but the system must hold five clocks
        if (rst_n_sync) begin
          mode_d  = MEMORY_MODE_SELECT_I;
          bus_d.addr_oe = 1'b1;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!rst_n_sync) begin
          bus_d.addr_oe = 1'b0;
          state_d = ST_HOLD;
        end else begin
          bus_d.strobe_oe = 1'b1;
          bus_d.addr      = PC_RESET;
          pc_d            = pc_next(PC_RESET);
          run_d           = 1'b1;
          state_d         = ST_RUN;
        end
      end
    endcase
    if (SRST_I) begin
      state_d   = ST_HOLD;
      bus_d     = '{rd_n: 1'b1, wr_n: 1'b1, strobe_oe: 1'b0, addr: PC_RESET,
                    addr_oe: 1'b0, data: DATA_RESET, data_oe: 1'b0};
      pc_d      = PC_RESET;
      clk_out_d = 1'b0;
      mode_d    = 1'b0;
      run_d     = 1'b0;
    end else if (!CE_I) begin
      state_d   = state_q;
      bus_d     = bus_q;
      pc_d      = pc_q;
      clk_out_d = clk_out_q;
      mode_d    = mode_q;
      run_d     = run_q;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    state_q   <= state_d;
    bus_q     <= bus_d;
    pc_q      <= pc_d;
    clk_out_q <= clk_out_d;
    mode_q    <= mode_d;
    run_q     <= run_d;
  end

  assign CLOCK_OUT_O      = clk_out_q;
  assign RD_N_O           = bus_q.rd_n;
  assign WR_N_O           = bus_q.wr_n;
  assign STROBE_OE_O      = bus_q.strobe_oe;
  assign ADDRESS_BUS_O    = bus_q.addr;
  assign ADDRESS_BUS_OE_O = bus_q.addr_oe;
  assign DATA_BUS_O       = bus_q.data;
  assign DATA_BUS_OE_O    = bus_q.data_oe;
  assign MODE_LATCHED_O   = mode_q;
  assign RUN_O            = run_q;
endmodule

//--- drb_pkg.sv
// Constants and types for the reset and bus release sequencer
// Functional notes
// - On reset the read and write strobes are first driven inactive high before they and the address bus float; the data bus floats already in that first cycle.
// - While reset is held, data bus, both strobes and address bus go to high impedance.
// - Address outputs and program counter clear to zero after the next full clock after reset.
// - Execution resumes from address zero one full clock after reset is released.
// - Reset passes a synchroniser, so response latency depends on where its edge falls.
// - Read and write strobes are never active in the same cycle.
package drb_pkg;
  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 12;
  localparam int          MIN_RST_CYC = 5;
  localparam logic [11:0] PC_RESET    = 12'h000;
  localparam logic [15:0] DATA_RESET  = 16'h0000;

  // ************************************
  // Sequencer states
  // ************************************
  typedef enum logic [4:0] {
    ST_RUN     = 5'b00001,
    ST_STROBE  = 5'b00010,
    ST_FLOAT   = 5'b00100,
    ST_HOLD    = 5'b01000,
    ST_RELEASE = 5'b10000
  } drb_state_t;

  typedef struct packed {
    logic        rd_n;
    logic        wr_n;
    logic        strobe_oe;
    logic [11:0] addr;
    logic        addr_oe;
    logic [15:0] data;
    logic        data_oe;
  } drb_bus_t;
endpackage

//--- drb_sync.sv
// Two-stage synchroniser for the reset input
`timescale 1ns/1ns
module drb_sync
  import drb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic ce_i,
  input  wire logic srst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_o;
    if (srst_i) begin
      // Preset to asserted, so a pin held low gives no false start
      meta_d = 1'b0;
      sync_d = 1'b0;
    end else if (ce_i) begin
      meta_d = async_i;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_o <= sync_d;
  end
endmodule

//--- drb_monitor.sv
// Checker for the reset and bus release sequencer
`timescale 1ns/1ns
module drb_monitor
  import drb_pkg::*;
#(parameter int AW = ADDR_W, parameter int DW = DATA_W) (
  input wire logic REF_CLK_I, SRST_I, RESET_IN_N_I, RD_N_O, WR_N_O, STROBE_OE_O,
  input wire logic ADDRESS_BUS_OE_O, DATA_BUS_OE_O, RUN_O,
  input wire logic [AW-1:0] ADDRESS_BUS_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  a_strobe_before_float: assert property ($fell(STROBE_OE_O) |->
    $past(RD_N_O) && $past(WR_N_O)) else $error("strobes floated while active");
  a_bus_float: assert property ($fell(RESET_IN_N_I) |->
    ##[3:5] !(STROBE_OE_O || ADDRESS_BUS_OE_O || DATA_BUS_OE_O)) else $error("bus not floated");
  a_addr_clear: assert property (!RESET_IN_N_I [*6] |->
    ADDRESS_BUS_O == '0 && !RUN_O) else $error("address not cleared");
  a_run_resume: assert property ($rose(RESET_IN_N_I) |->
    ##[3:5] RUN_O && ADDRESS_BUS_O == '0) else $error("no resume at zero");
  a_sync_release: assert property ($rose(RUN_O) |->
    $past(RESET_IN_N_I, 3) && $past(RESET_IN_N_I, 2)) else $error("run before sync");
  a_strobe_excl: assert property (RD_N_O || WR_N_O)
    else $error("both strobes active");
  a_addr_enable: assert property ($rose(RUN_O) |->
    ADDRESS_BUS_OE_O && $past(ADDRESS_BUS_OE_O)) else $error("fetch before address enable");
  c_float: cover property ($fell(STROBE_OE_O));
  c_run: cover property ($rose(RUN_O));
  c_write: cover property (!WR_N_O && DATA_BUS_OE_O);
endmodule
bind drb_reset_bus_release drb_monitor #(.AW(AW), .DW(DW)) drb_monitor_i (.*);

//--- drb_mem_model.sv
// External memory model on the shared bus
`timescale 1ns/1ns
module drb_mem_model (
  input  wire logic        clk_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        d_oe_i,
  output logic      [15:0] line_o
);
  logic [15:0] mem_q [0:4095];
  // Released line flips so a stale value never looks driven
  always @(posedge clk_i) begin
    line_o <= d_oe_i ? data_i : ~line_o;
    if (!wr_n_i && oe_i) mem_q[addr_i] <= data_i;
  end
endmodule

//--- drb_reset_bus_release_test.sv
// Self-checking bench for the reset and bus release sequencer
`timescale 1ns/1ns
module drb_reset_bus_release_test;
  import drb_pkg::*;
  logic clk = 0, srst = 1, rn = 0, mode = 0, rq = 0, wq = 0, msel = 0, pr, pw;
  logic rd_n, wr_n, s_oe, a_oe, d_oe, mlat, run, clk_out, pco, ce = 1;
  logic [11:0] addr;
  logic [15:0] dbus, pd, wd = 16'h0000;
  logic [31:0] x = 32'hE7F2;
  int n_mismatch = 0, n_tests = 0, pc;
  drb_reset_bus_release drb_reset_bus_release_i (.REF_CLK_I(clk), .SRST_I(srst), .CE_I(ce),
    .RESET_IN_N_I(rn), .MEMORY_MODE_SELECT_I(mode), .RD_REQ_I(rq), .WR_REQ_I(wq),
    .WR_DATA_I(wd), .CLOCK_OUT_O(clk_out), .RD_N_O(rd_n), .WR_N_O(wr_n), .STROBE_OE_O(s_oe),
    .ADDRESS_BUS_O(addr), .ADDRESS_BUS_OE_O(a_oe), .DATA_BUS_O(dbus),
    .DATA_BUS_OE_O(d_oe), .MODE_LATCHED_O(mlat), .RUN_O(run));
  drb_mem_model drb_mem_model_i (.clk_i(clk), .wr_n_i(wr_n), .oe_i(s_oe), .addr_i(addr),
    .data_i(dbus), .d_oe_i(d_oe), .line_o());
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Random requests every edge, also while in reset
  task automatic step(input logic r);
    @(posedge clk);
    x = xs(x);
    rn <= r;
    mode <= msel;
    rq <= x[0];
    wq <= x[1];
    wd <= x[31:16];
    #1;
  endtask
  task automatic release_run;
    repeat (5) step(1);
    chk("start", {addr, a_oe, s_oe, run, mlat}, {12'h000, 3'h7, msel});
    pc = 0;
    repeat (30) begin
      pr = rq;
      pw = wq & ~rq;
      pd = wd;
      pco = clk_out;
      step(1);
      pc++;
      chk("clock_out", {15'h0000, clk_out}, {15'h0000, ~pco});
      chk("addr", 16'(addr), 16'(pc));
      chk("strobes", {12'h000, s_oe, rd_n, wr_n, d_oe}, {12'h001, ~pr, ~pw, pw});
      chk("data", d_oe ? dbus : 16'h0000, pw ? pd : 16'h0000);
    end
  endtask
  // Clock enable low must hold address, clock out, both strobes and run still
  task automatic freeze_check;
    logic [15:0] snap;
    @(posedge clk);
    ce <= 1'b0;
    #1;
    snap = {addr, clk_out, rd_n, wr_n, run};
    repeat (3) step(1);
    chk("frozen", {addr, clk_out, rd_n, wr_n, run}, snap);
    @(posedge clk);
    ce <= 1'b1;
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 0;
    repeat (5) step(0);
    release_run;
    freeze_check;
    for (int k = 0; k < 4; k++) begin
      msel = x[9];
      repeat (4) step(0);
      chk("forced", {14'h0000, rd_n, wr_n}, 16'h0003);
      step(0);
      chk("float", {13'h0000, s_oe, a_oe, d_oe}, 16'h0000);
      step(0);
      chk("clear", {addr, 3'h0, run}, 16'h0000);
      repeat (2 * k) step(0);
      release_run;
    end
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
